/* File: include/spc_consts.svh */
// register map, field positions and timing counts of the port control block
//
// Behaviour
// - bus takes 8-, 16- and 32-bit writes through per-byte strobes
// - protected fields change only while the port is disabled
// - bit 30 picks shift order: 0 msb first, 1 lsb first
// - bit 29 sets serial clock idle level, low or high
// - bit 28 picks sampling on leading or trailing edge
// - polarity and phase give four transfer modes
// - frame format bits 27:24: 0x0 plain, 0x2 address-led, slave only
// - address-led frames compare first byte with the match address
// - bits 21:20 pick which pad feeds the serial input line
// - serial input is master-in as master, master-out as slave
// - serial output drives master-out as master, master-in as slave
// - bits 17:16 map output, clock and slave-select pads
// - slave select pad follows bits 17:16 only in slave mode
// - bit 8 times the overrun flag: in stream or at once
// - slave without run-in-standby drops all reception in standby
// - slave with run-in-standby keeps transferring, wakes on receive
// - master without run-in-standby stops core clock after transfer
// - master with run-in-standby keeps core clock, wakes on byte complete
// - configuration fields act at once, only enable and reset sync
// - mode field 0x2 is slave, 0x3 is master
// - soft reset returns registers to reset, disables, beats other writes
// - enable reads back at once, busy flag until sync completes
`ifndef SPC_CONSTS_SVH
`define SPC_CONSTS_SVH
`define SPC_OFF_CTRL 8'h00
`define SPC_OFF_STAT 8'h04
`define SPC_OFF_TXD 8'h08
`define SPC_OFF_RXD 8'h0C
`define SPC_OFF_MADR 8'h10
`define SPC_CTRL_RST 32'h0000_0000
`define SPC_CTRL_WMASK 32'h7F33_019E
`define SPC_B_SOFT_RESET_REQUEST 0
`define SPC_B_EN 1
`define SPC_B_RUNSB 7
`define SPC_B_OVERFLOW_NOTIFY_TIMING 8
`define SPC_B_CLOCK_SAMPLE_PHASE 28
`define SPC_B_CLOCK_IDLE_LEVEL 29
`define SPC_B_LSB 30
`define SPC_MODE_SLV 3'h2
`define SPC_MODE_MST 3'h3
`define SPC_FRAME_FORMAT_ADDR 4'h2
`define SPC_ST_OVF 2
`define SPC_SYNC 4
`define SPC_DIV 4
`define SPC_LAST_EDGE 4'hF
`define SPC_OKAY 2'b00
`define SPC_SLVERR 2'b10
`define SPC_DECERR 2'b11
`endif

/* File: include/spc_pkg.sv */
// types of the port control block
package spc_pkg;
  typedef enum logic [0:0] {SPC_IDLE, SPC_RUN} spc_mst_t;
  typedef struct packed {
    logic [31:0] ctrl;
    logic en_core;
    logic pend_en;
    logic pend_rst;
    logic [3:0] scnt;
    logic aw_ok;
    logic w_ok;
    logic [7:0] awa;
    logic [31:0] wd;
    logic [3:0] ws;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [3:0] p1;
    logic [3:0] p2;
    logic sck_q;
    spc_mst_t mst;
    logic [7:0] div;
    logic mclk;
    logic [3:0] ecnt;
    logic [7:0] tsh;
    logic [7:0] rsh;
    logic [7:0] txb;
    logic [7:0] rxb;
    logic [7:0] madr;
    logic txf;
    logic rxv;
    logic ovf;
    logic ovf_pend;
    logic first;
    logic hit;
    logic [3:0] pad_out;
    logic [3:0] pad_oe;
    logic clk_req;
    logic wake;
  } spc_st_t;
endpackage : spc_pkg

/* File: rtl/spc_ctrl.sv */
// serial port control register, pad routing and byte shift engine
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ns
`include "spc_consts.svh"
module spc_ctrl #(
  parameter int DIV = `SPC_DIV,
  parameter int SYNC = `SPC_SYNC
) (
  input wire logic aclk, // bus and core clock
  input wire logic aresetn, // synchronous reset
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic [3:0] pad_in, // pad levels from outside
  output logic [3:0] pad_out, // pad drive levels
  output logic [3:0] pad_oe, // pad drive enables
  input wire logic standby, // system in standby sleep
  output logic core_clock_req, // core clock wanted
  output logic wake_req // wake pulse
);
  import spc_pkg::*;

  spc_st_t s;
  spc_st_t n;

  // byte strobes widened to a bit mask
  function automatic logic [31:0] strb_mask(input logic [3:0] st);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{st[i]}};
    end
    return m;
  endfunction : strb_mask

  // output, clock and select pads per pinout code
  function automatic logic [5:0] pad_map(input logic [1:0] sel);
    case (sel)
      2'd0: pad_map = {2'd0, 2'd1, 2'd2};
      2'd1: pad_map = {2'd2, 2'd3, 2'd1};
      2'd2: pad_map = {2'd3, 2'd1, 2'd2};
      default: pad_map = {2'd0, 2'd3, 2'd1};
    endcase
  endfunction : pad_map

  // shift one bit into a byte in the chosen order
  function automatic logic [7:0] shift_in(input logic [7:0] v, input logic b, input logic lsb_first);
    return lsb_first ? {b, v[7:1]} : {v[6:0], b};
  endfunction : shift_in

  // configuration decode, read straight from the register without sync
  logic lsb;
  logic clock_idle_level;
  logic clock_sample_phase;
  logic overflow_notify_timing;
  logic runsb;
  logic master;
  logic slave;
  logic addr_fmt;
  logic [1:0] do_p;
  logic [1:0] sck_p;
  logic [1:0] ss_p;
  logic di;
  logic sck_in;
  logic ss_n_in;
  logic prot;
  logic drop;
  logic out_bit;
  assign lsb = s.ctrl[`SPC_B_LSB];
  assign clock_idle_level = s.ctrl[`SPC_B_CLOCK_IDLE_LEVEL];
  assign clock_sample_phase = s.ctrl[`SPC_B_CLOCK_SAMPLE_PHASE];
  assign overflow_notify_timing = s.ctrl[`SPC_B_OVERFLOW_NOTIFY_TIMING];
  assign runsb = s.ctrl[`SPC_B_RUNSB];
  assign master = s.en_core && (s.ctrl[4:2] == `SPC_MODE_MST);
  assign slave = s.en_core && (s.ctrl[4:2] == `SPC_MODE_SLV);
  assign addr_fmt = s.ctrl[27:24] == `SPC_FRAME_FORMAT_ADDR;
  assign {do_p, sck_p, ss_p} = pad_map(s.ctrl[17:16]);
  assign di = s.p2[s.ctrl[21:20]];
  assign sck_in = s.p2[sck_p];
  assign ss_n_in = s.p2[ss_p];
  assign prot = s.ctrl[`SPC_B_EN] || s.en_core;
  assign drop = slave && standby && !runsb;
  assign out_bit = lsb ? s.tsh[0] : s.tsh[7];

  // all next-state logic
  always_comb begin
    logic [31:0] m;
    logic [31:0] nc;
    logic ev;
    logic lead;
    logic smp;
    logic chg;
    logic done;
    logic act;
    logic [7:0] rnew;
    logic [7:0] rx_byte;
    logic [3:0] po;
    logic [3:0] oe;
    m = '0;
    nc = '0;
    ev = 1'b0;
    lead = 1'b0;
    smp = 1'b0;
    chg = 1'b0;
    done = 1'b0;
    act = 1'b0;
    rnew = '0;
    rx_byte = '0;
    po = '0;
    oe = '0;
    n = s;
    n.wake = 1'b0;
    // pads pass two flops before use
    n.p1 = pad_in;
    n.p2 = s.p1;

    // write address and data are taken in either order
    if (s_axi_awvalid && s.awready) begin
      n.aw_ok = 1'b1;
      n.awa = {s_axi_awaddr[7:2], 2'b00};
    end
    if (s_axi_wvalid && s.wready) begin
      n.w_ok = 1'b1;
      n.wd = s_axi_wdata;
      n.ws = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    // write takes effect once both halves are in
    if (s.aw_ok && s.w_ok && !s.bvalid) begin
      n.aw_ok = 1'b0;
      n.w_ok = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = `SPC_OKAY;
      m = strb_mask(s.ws);
      if (s.pend_rst) begin
        // registers are frozen while the reset runs
        n.bresp = `SPC_SLVERR;
      end else if (s.awa == `SPC_OFF_CTRL) begin
        if (s.ws[0] && s.wd[`SPC_B_SOFT_RESET_REQUEST]) begin
          // soft reset discards the rest of this write
          n.ctrl = `SPC_CTRL_RST;
          n.ctrl[`SPC_B_SOFT_RESET_REQUEST] = 1'b1;
          n.pend_rst = 1'b1;
          n.scnt = 4'(SYNC);
        end else begin
          if (prot) begin
            m = m & (32'h1 << `SPC_B_EN);
          end
          m = m & `SPC_CTRL_WMASK;
          nc = (s.ctrl & ~m) | (s.wd & m);
          n.ctrl = nc;
          if (nc[`SPC_B_EN] != s.ctrl[`SPC_B_EN]) begin
            n.pend_en = 1'b1;
            n.scnt = 4'(SYNC);
          end
        end
      end else if (s.awa == `SPC_OFF_STAT) begin
        if (s.ws[0] && s.wd[`SPC_ST_OVF]) begin
          n.ovf = 1'b0;
        end
      end else if (s.awa == `SPC_OFF_TXD) begin
        if (s.ws[0]) begin
          n.txb = s.wd[7:0];
          n.txf = 1'b1;
        end
      end else if (s.awa == `SPC_OFF_MADR) begin
        if (s.ws[0] && !prot) begin
          n.madr = s.wd[7:0];
        end
      end else if (s.awa != `SPC_OFF_RXD) begin
        n.bresp = `SPC_DECERR;
      end
    end
    n.awready = !n.aw_ok;
    n.wready = !n.w_ok;

    // reads answer one cycle after the address is taken
    if (s.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s.arready) begin
      n.rvalid = 1'b1;
      n.rresp = `SPC_OKAY;
      n.rdata = '0;
      if (s_axi_araddr[7:2] == `SPC_OFF_CTRL >> 2) begin
        n.rdata = s.ctrl;
      end else if (s_axi_araddr[7:2] == `SPC_OFF_STAT >> 2) begin
        n.rdata = {24'h0, (s.mst == SPC_RUN), s.en_core, s.hit, s.txf,
                   s.rxv, s.ovf, s.pend_en, s.pend_rst};
      end else if (s_axi_araddr[7:2] == `SPC_OFF_TXD >> 2) begin
        n.rdata = {24'h0, s.txb};
      end else if (s_axi_araddr[7:2] == `SPC_OFF_RXD >> 2) begin
        n.rdata = {24'h0, s.rxb};
        n.rxv = 1'b0;
        // in-stream notice: flag lands where the lost byte would be
        if (s.ovf_pend) begin
          n.ovf = 1'b1;
          n.ovf_pend = 1'b0;
        end
      end else if (s_axi_araddr[7:2] == `SPC_OFF_MADR >> 2) begin
        n.rdata = {24'h0, s.madr};
      end else begin
        n.rresp = `SPC_DECERR;
      end
    end
    n.arready = !n.rvalid;

    // edge finder: master ticks its own divider, slave watches the pad
    n.sck_q = sck_in;
    act = slave && !ss_n_in && !drop;
    if (master) begin
      ev = (s.mst == SPC_RUN) && (s.div == 8'h00);
      lead = s.mclk == clock_idle_level;
    end else begin
      ev = act && (sck_in != s.sck_q);
      lead = s.sck_q == clock_idle_level;
    end
    smp = ev && (lead ^ clock_sample_phase);
    chg = ev && !(lead ^ clock_sample_phase) && (s.ecnt != 4'h0);
    done = ev && (s.ecnt == `SPC_LAST_EDGE);
    rnew = shift_in(s.rsh, di, lsb);
    rx_byte = smp ? rnew : s.rsh;
    if (ev) begin
      n.ecnt = s.ecnt + 4'h1;
    end
    if (smp) begin
      n.rsh = rnew;
    end
    if (chg) begin
      n.tsh = lsb ? {1'b0, s.tsh[7:1]} : {s.tsh[6:0], 1'b0};
    end

    // master divider and clock level
    if (s.mst == SPC_RUN) begin
      n.div = (s.div == 8'h00) ? 8'(DIV - 1) : s.div - 8'h01;
      if (ev) begin
        n.mclk = !s.mclk;
      end
    end else begin
      n.mclk = clock_idle_level;
    end
    // a new master byte waits while the core clock is to stop
    if (master && (s.mst == SPC_IDLE) && s.txf && !(standby && !runsb)) begin
      n.mst = SPC_RUN;
      n.tsh = s.txb;
      n.txf = 1'b0;
      n.div = 8'(DIV - 1);
      n.ecnt = 4'h0;
    end

    // slave frame boundary, or reception dropped in standby
    if (slave && !act) begin
      n.ecnt = 4'h0;
      n.first = 1'b1;
      if (ss_n_in) begin
        n.hit = 1'b0;
      end
      if (s.txf && ss_n_in) begin
        n.tsh = s.txb;
        n.txf = 1'b0;
      end
    end

    // byte complete: address check or delivery to the receive buffer
    if (done) begin
      n.ecnt = 4'h0;
      if (master) begin
        n.mst = SPC_IDLE;
      end else if (s.txf) begin
        n.tsh = s.txb;
        n.txf = 1'b0;
      end
      if (slave && addr_fmt && s.first) begin
        n.first = 1'b0;
        n.hit = rx_byte == s.madr;
      end else if (!(slave && addr_fmt) || s.hit) begin
        // set beats a read clearing the buffer in this cycle
        if (s.rxv && n.rxv) begin
          if (overflow_notify_timing) begin
            n.ovf = 1'b1;
          end else begin
            n.ovf_pend = 1'b1;
          end
        end else begin
          n.rxb = rx_byte;
          n.rxv = 1'b1;
        end
        n.wake = standby;
      end
    end

    // pads: only the routed pads are driven
    if (master) begin
      po[do_p] = out_bit;
      oe[do_p] = 1'b1;
      po[sck_p] = s.mclk;
      oe[sck_p] = 1'b1;
    end else if (act) begin
      po[do_p] = out_bit;
      oe[do_p] = 1'b1;
    end
    n.pad_out = po;
    n.pad_oe = oe;
    // core clock kept on in standby only if asked, or to finish a byte
    n.clk_req = s.en_core && (runsb || !standby || (s.mst == SPC_RUN));

    // synchronised enable and soft reset complete after a fixed delay
    if (s.pend_rst || s.pend_en) begin
      if (s.scnt == 4'h0) begin
        n.pend_en = 1'b0;
        n.en_core = s.ctrl[`SPC_B_EN];
        if (s.pend_rst) begin
          n.ctrl = `SPC_CTRL_RST;
          n.pend_rst = 1'b0;
          n.en_core = 1'b0;
          n.txf = 1'b0;
          n.rxv = 1'b0;
          n.ovf = 1'b0;
          n.ovf_pend = 1'b0;
          n.madr = '0;
          n.txb = '0;
          n.rxb = '0;
          n.mst = SPC_IDLE;
          n.ecnt = 4'h0;
          n.hit = 1'b0;
        end
      end else begin
        n.scnt = s.scnt - 4'h1;
      end
    end
  end

  // single state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  // outputs come straight from the state flops
  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bresp = s.bresp;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_arready = s.arready;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign s_axi_rvalid = s.rvalid;
  assign pad_out = s.pad_out;
  assign pad_oe = s.pad_oe;
  assign core_clock_req = s.clk_req;
  assign wake_req = s.wake;
endmodule : spc_ctrl

/* File: verif/spc_ctrl_chk.sv */
// bus handshake and wake pulse checks on the port control block's pins
`timescale 1ns/1ns
module spc_ctrl_chk (
  input wire logic aclk, // clock
  input wire logic aresetn, // reset
  input wire logic s_axi_awvalid, // aw valid
  input wire logic s_axi_awready, // aw ready
  input wire logic s_axi_wvalid, // w valid
  input wire logic s_axi_wready, // w ready
  input wire logic s_axi_bvalid, // b valid
  input wire logic s_axi_bready, // b ready
  input wire logic s_axi_arvalid, // ar valid
  input wire logic s_axi_arready, // ar ready
  input wire logic s_axi_rvalid, // r valid
  input wire logic s_axi_rready, // r ready
  input wire logic [31:0] s_axi_rdata, // r data
  input wire logic standby, // standby
  input wire logic wake_req // wake
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // answers arrive at the promised latency and stand until taken
  a_rd_answer:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
  a_wr_answer:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid
      |-> ##2 s_axi_bvalid) else $error("write answer late");
  a_b_hold:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("write answer dropped");
  a_r_hold:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer changed");
  a_one_read:
    assert property (s_axi_rvalid |-> !s_axi_arready) else $error("second read taken");
  a_ready_back:
    assert property ($rose(aresetn) |-> !s_axi_awready ##[1:2] s_axi_awready) else $error("no ready after reset");
  // wake is one pulse, caused only while asleep
  a_wake_pulse:
    assert property (wake_req |=> !wake_req) else $error("wake too long");
  a_wake_cause:
    assert property (wake_req |-> $past(standby)) else $error("wake while awake");
  c_wake: cover property (wake_req);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_write: cover property (s_axi_bvalid && s_axi_bready);
endmodule : spc_ctrl_chk
bind spc_ctrl spc_ctrl_chk i_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
  .standby, .wake_req);

/* File: verif/spc_peer.sv */
// far-side serial slave model
`timescale 1ns/1ns
module spc_peer (
  input wire logic [3:0] pad_out, // port pads
  input wire logic [1:0] ck, // clock pad
  input wire logic [1:0] mo, // data-in pad
  input wire logic clock_idle_level, // idle level
  input wire logic clock_sample_phase, // phase
  input wire logic lsb, // lsb first
  input wire logic arm, // rise starts a byte
  input wire logic [7:0] px, // byte sent back
  output logic so, // data to port
  output logic [7:0] prx, // byte taken
  output int nbit // bits sampled
);
  int o;
  // past the last bit the line shows the inverse of its last value
  function automatic logic pick(input int i);
    return (i > 7) ? ~so : (lsb ? px[i] : px[7 - i]);
  endfunction : pick
  // first bit stands before the leading edge
  always @(posedge arm) begin
    o = 0;
    nbit = 0;
    prx = 8'h00;
    so = pick(0);
  end
  // sample on one edge, shift out on the other; ignored while not armed
  always @(pad_out[ck]) begin
    if (arm) begin
      if ((pad_out[ck] != clock_idle_level) ^ clock_sample_phase) begin
        prx = lsb ? {pad_out[mo], prx[7:1]} : {prx[6:0], pad_out[mo]};
        nbit++;
      end else begin
        o = o + (clock_sample_phase ? 0 : 1);
        so = pick(o);
        o = o + (clock_sample_phase ? 1 : 0);
      end
    end
  end
endmodule : spc_peer

/* File: verif/tb_top.sv */
// self-checking bench: register access and one byte per transfer mode
`timescale 1ns/1ns
`include "spc_consts.svh"
module tb_top;
  localparam logic [7:0] CT = `SPC_OFF_CTRL, ST = `SPC_OFF_STAT, TD = `SPC_OFF_TXD, RD = `SPC_OFF_RXD;
  localparam logic [7:0] CKT = 8'hDD, DOT = 8'h38, DIT = 8'h42, SST = 8'h66;
  logic aclk = 1'b0, aresetn = 1'b0, awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic stby = 1'b0, arm = 1'b0, woke = 1'b0, awr, wrd, bv, arr, rv, ck_req, wake, so, lsb, clock_idle_level, clock_sample_phase;
  logic [7:0] awa = '0, ara = '0, tx, px, prx;
  logic [31:0] wd = '0, d, c, rdat;
  logic [3:0] ws = '0, pad_in, pad_out, pad_oe;
  logic [1:0] r, br, rr, ck, mo, di;
  // slave scenario: the bench plays the far-side master straight on the pads
  logic slv = 1'b0, s_ck = 1'b0, s_ss = 1'b1, s_mo = 1'b0;
  logic [7:0] sm = '0;
  localparam logic [7:0] SLB = 8'h3C, SLT = 8'hA5;
  int err_total = 0, n_tests = 0, cyc = 0, nbit, m;
  spc_ctrl i_dut (.aclk, .aresetn, .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv),
    .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .pad_in, .pad_out, .pad_oe, .standby(stby),
    .core_clock_req(ck_req), .wake_req(wake));
  spc_peer i_peer (.pad_out, .ck, .mo, .clock_idle_level, .clock_sample_phase, .lsb, .arm, .px, .so, .prx, .nbit);
  always #5 aclk = ~aclk;
  // undriven pads sit at their pull-up level
  // a model that is not armed lets its line go to the pull-up as well
  always_comb for (int i = 0; i < 4; i++) pad_in[i] = pad_oe[i] ? pad_out[i] :
    slv ? (i == 3 ? s_mo : i == 2 ? s_ss : i == 1 ? s_ck : 1'b1) :
    ((i == di && arm) ? so : 1'b1);
  // remember a wake pulse, it stands one cycle only
  always @(posedge aclk) if (wake) woke <= 1'b1;
  // cut a hang short
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      close_out();
    end
  end
  task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s);
    @(posedge aclk);
    awa <= a; wd <= v; ws <= s; awv <= 1'b1; wv <= 1'b1; bry <= 1'b1;
    for (int t = 0; t < 200; t++) begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
      if (bv) break;
    end
    bry <= 1'b0;
    r = br;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    ara <= a; arv <= 1'b1; rry <= 1'b1;
    for (int t = 0; t < 200; t++) begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
      if (rv) break;
    end
    rry <= 1'b0;
    d = rdat;
    r = rr;
  endtask : rd
  task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(n, d, e);
  endtask : rc
  // poll status until the masked bits read as wanted
  task automatic wt(input logic [31:0] k, input logic [31:0] v);
    for (int t = 0; t < 100; t++) begin
      rd(ST);
      if ((d & k) == v) break;
    end
  endtask : wt
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rc("ctrl_reset", CT, 32'h0);
    rd(8'h14);
    chk("unmapped", r, `SPC_DECERR);
    wr(8'h14, 32'h0, 4'hF);
    chk("unmapped_wr", r, `SPC_DECERR);
    wr(CT, 32'hFFFF_FFFC, 4'hF);
    rc("ctrl_all", CT, 32'h7F33_019C);
    wr(CT, 32'h0, 4'hC);
    rc("ctrl_half", CT, 32'h0000_019C);
    wr(CT, 32'h0, 4'h2);
    rc("ctrl_byte", CT, 32'h0000_009C);
    wr(CT, 32'h0000_000E, 4'hF);
    rd(ST);
    chk("sync_pending", d[1], 1'b1);
    rc("enable_back", CT, 32'h0000_000E);
    wr(CT, 32'h4000_000E, 4'hF);
    rc("locked", CT, 32'h0000_000E);
    wr(CT, 32'h4000_0001, 4'hF);
    wr(CT, 32'h0, 4'hF);
    chk("reset_busy", r, `SPC_SLVERR);
    wt(32'h1, 32'h0);
    rc("soft_reset", CT, 32'h0);
    // master transfer in each mode with its own pad map; the last two asleep
    for (m = 0; m < 4; m++) begin
      clock_idle_level = m[1]; clock_sample_phase = m[0]; lsb = m[1] ^ m[0];
      ck = CKT[2*m +: 2]; mo = DOT[2*m +: 2]; di = DIT[2*m +: 2];
      tx = 8'h1D + 8'(m); px = 8'hB2 - 8'(m);
      c = {1'h0, lsb, clock_idle_level, clock_sample_phase, 6'h0, di, 2'h0, m[1:0], 8'h0, m == 2, 7'h0C};
      wr(CT, c, 4'hF);
      wr(CT, c | 32'h2, 4'hF);
      wt(32'h2, 32'h0);
      chk("idle", {pad_oe[ck], pad_out[ck]}, {1'b1, clock_idle_level});
      chk("ss_pad", pad_oe[SST[2*m +: 2]], 1'b0);
      arm <= 1'b1;
      woke <= 1'b0;
      wr(TD, {24'h0, tx}, 4'h1);
      wt(32'h80, 32'h80);
      stby <= (m > 1);
      wt(32'h8, 32'h8);
      chk("mosi", prx, tx);
      chk("edges", nbit, 8);
      if (m > 1) chk("clk_req", ck_req, m == 2);
      if (m > 1) chk("wake", woke, 1'b1);
      rd(RD);
      chk("miso", d, {24'h0, px});
      arm <= 1'b0;
      stby <= 1'b0;
      wr(CT, c, 4'hF);
      wt(32'h2, 32'h0);
    end
    // slave, mode 0, plain frame: output pad 0, clock pad 1, select pad 2, input pad 3
    slv = 1'b1;
    wr(CT, 32'h0030_0008, 4'hF);
    wr(CT, 32'h0030_000A, 4'hF);
    wt(32'h2, 32'h0);
    wr(TD, {24'h0, SLT}, 4'h1);
    // six cycles per half clock cover the two-flop pad delay and the output flop
    for (int b = 7; b >= 0; b--) begin
      s_ss <= 1'b0;
      s_mo <= SLB[b];
      repeat (6) @(posedge aclk);
      s_ck <= 1'b1;
      sm[b] = pad_out[0];
      repeat (6) @(posedge aclk);
      s_ck <= 1'b0;
    end
    repeat (6) @(posedge aclk);
    chk("slave_ss_pad", pad_oe[2], 1'b0);
    s_ss <= 1'b1;
    wt(32'h8, 32'h8);
    chk("slave_miso", sm, SLT);
    rc("slave_rx", RD, {24'h0, SLB});
    close_out();
  end
endmodule : tb_top
